//--- design/elt_top.sv
// Encoder line trigger: quadrature decoder, gating and fractional divider
module elt_top
    import elt_pkg::*;
(
    // Clock, reset and enable
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic               clk_en,
    // Encoder pins
    input  wire logic               enc_a,
    input  wire logic               enc_b,
    // Register port
    input  wire logic [3:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [31:0]             reg_rdata,
    // Trigger outputs
    output logic                    line_trig,
    output logic                    frame_trig,
    output logic                    div_out
);
    import elt_pkg::*;

    logic [2:0]      a_sync;
    logic [2:0]      b_sync;
    logic [31:0]     div_ctrl;
    logic [31:0]     dec_ctrl;
    logic [23:0]     win_ul;
    logic [23:0]     pos;
    logic [23:0]     hi_mark;
    logic [23:0]     lo_mark;
    logic            dir_up;
    logic [15:0]     step_cnt;
    elt_div_cfg_t    dcfg;
    elt_status_t     stat;
    logic            cnt_edge;
    logic            up_edge;
    logic            qualified;
    logic            dec_rst;

    // Clamp a written exponent into the legal range
    function automatic logic [2:0] clamp_exp(input logic [2:0] v);
        return (v > EXP_MAX) ? EXP_MAX : v;
    endfunction

    // Clamp a written divisor into the legal range
    function automatic logic [9:0] clamp_div(input logic [9:0] v);
        return (v < DIV_MIN) ? DIV_MIN : v;
    endfunction

    // Input synchronisers, stage 0 read only by stage 1
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            a_sync <= 3'h0;
            b_sync <= 3'h0;
        end else if (clk_en) begin
            a_sync <= {a_sync[1:0], enc_a};
            b_sync <= {b_sync[1:0], enc_b};
        end
    end

    // Edge decode from stages 1 and 2 only
    logic a_now, a_old, b_now, b_old;
    logic a_chg, b_chg, a_rise, b_rise;
    logic step_up;
    assign a_now  = a_sync[1];
    assign a_old  = a_sync[2];
    assign b_now  = b_sync[1];
    assign b_old  = b_sync[2];
    assign a_chg  = a_now ^ a_old;
    assign b_chg  = b_now ^ b_old;
    assign a_rise = a_now & ~a_old;
    assign b_rise = b_now & ~b_old;
    // Forward when A leads B
    assign step_up = a_chg ? (a_now ^ b_now) : ~(a_now ^ b_now);
    assign cnt_edge = dec_ctrl[F_MULT] ? (a_chg | b_chg)
                                       : (a_rise | b_rise);
    assign up_edge  = step_up;
    assign dec_rst  = reg_wr && reg_addr == REG_DEC_CTRL
                      && reg_wdata[F_RESET];

    // Position counter with direction
    logic [23:0] next_pos;
    assign next_pos = up_edge ? pos + 24'h000001 : pos - 24'h000001;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pos    <= 24'h000000;
            dir_up <= 1'b1;
        end else if (clk_en) begin
            if (dec_rst) begin
                pos <= 24'h000000;
            end else if (cnt_edge) begin
                pos    <= next_pos;
                dir_up <= up_edge;
            end
        end
    end

    // Gating of counted edges into line triggers
    logic dir_ok, win_ok, new_ok, in_win;
    always_comb begin
        case (elt_dir_t'(dec_ctrl[F_DIR_LO +: 2]))
            ELT_DIR_BOTH: dir_ok = 1'b1;
            ELT_DIR_POS:  dir_ok = up_edge;
            ELT_DIR_NEG:  dir_ok = ~up_edge;
            default:      dir_ok = 1'b0;
        endcase
    end
    assign in_win = pos >= dec_ctrl[23:0] && pos <= win_ul;
    assign win_ok = ~dec_ctrl[F_WIN] ||
                    (next_pos >= dec_ctrl[23:0] && next_pos <= win_ul);
    // Only counts beyond the extremes ever reached are new
    // Signed compare so that counts below zero are new on the reverse side
    assign new_ok = ~dec_ctrl[F_SINGLE] ||
                    (up_edge ? $signed(next_pos) > $signed(hi_mark)
                             : $signed(next_pos) < $signed(lo_mark));
    assign qualified = cnt_edge & dir_ok & win_ok & new_ok;

    // Reached extremes for single capture
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hi_mark <= 24'h000000;
            lo_mark <= 24'h000000;
        end else if (clk_en) begin
            if (dec_rst) begin
                hi_mark <= 24'h000000;
                lo_mark <= 24'h000000;
            end else if (cnt_edge && up_edge &&
                         $signed(next_pos) > $signed(hi_mark)) begin
                hi_mark <= next_pos;
            end else if (cnt_edge && !up_edge &&
                         $signed(next_pos) < $signed(lo_mark)) begin
                lo_mark <= next_pos;
            end
        end
    end

    // Line and frame triggers, one-cycle pulses
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            line_trig  <= 1'b0;
            frame_trig <= 1'b0;
            step_cnt   <= 16'h0000;
        end else if (clk_en) begin
            line_trig  <= qualified;
            frame_trig <= 1'b0;
            if (dec_rst) begin
                step_cnt <= 16'h0000;
            end else if (qualified && dec_ctrl[F_STEP]) begin
                if (step_cnt + 16'h0001 >= div_ctrl[F_STEP_LO +: 16]) begin
                    step_cnt   <= 16'h0000;
                    frame_trig <= 1'b1;
                end else begin
                    step_cnt <= step_cnt + 16'h0001;
                end
            end
        end
    end

    // Divider: period measure of A, output toggles at scaled rate
    logic [15:0] per_cnt;
    logic [15:0] per_meas;
    typedef enum logic [1:0] {
        ELT_DV_SLOW = 2'b00,
        ELT_DV_ARM  = 2'b01,
        ELT_DV_RUN  = 2'b10
    } elt_div_state_t;
    elt_div_state_t div_state;
    logic        slow;
    logic [25:0] out_acc;
    logic [10:0] slow_div;
    logic        div_in_rise;
    logic [25:0] out_step;
    assign dcfg.exponent   = div_ctrl[F_EXP_LO +: 3];
    assign dcfg.divisor    = div_ctrl[F_DIV_LO +: 10];
    assign dcfg.free_run   = div_ctrl[F_FREE];
    assign dcfg.stall_hold = div_ctrl[F_STALL];
    assign div_in_rise     = a_rise;
    // Half-period of output = per_meas * M / 2^(N+1), accumulated per clk
    assign out_step = 26'(32'(1) << dcfg.exponent) << 1;
    assign slow     = (div_state != ELT_DV_RUN);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            per_cnt  <= 16'h0000;
            per_meas  <= 16'h0000;
            div_state <= ELT_DV_SLOW;
        end else if (clk_en) begin
            if (div_in_rise) begin
                per_meas <= per_cnt + 16'h0001;
                per_cnt  <= 16'h0000;
            end else if (per_cnt < 16'(SLOW_CYC)) begin
                per_cnt  <= per_cnt + 16'h0001;
            end
            // Lock only after one whole input period has been measured
            case (div_state)
                ELT_DV_SLOW: begin
                    if (div_in_rise) begin
                        div_state <= ELT_DV_ARM;
                    end
                end
                ELT_DV_ARM, ELT_DV_RUN: begin
                    if (div_in_rise) begin
                        div_state <= ELT_DV_RUN;
                    end else if (per_cnt >= 16'(SLOW_CYC)) begin
                        div_state <= ELT_DV_SLOW;
                    end
                end
                default: div_state <= ELT_DV_SLOW;
            endcase
        end
    end

    logic [25:0] half_target;
    assign half_target = 26'(per_meas) * 26'(dcfg.divisor);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            out_acc  <= 26'h0000000;
            slow_div <= 11'h000;
            div_out  <= 1'b0;
        end else if (clk_en) begin
            if (slow) begin
                out_acc <= 26'h0000000;
                if (!dcfg.stall_hold && div_in_rise) begin
                    // Toggle every 2M input rises: one output period per 4M
                    if (slow_div + 11'h001 >= {dcfg.divisor, 1'b0}) begin
                        slow_div <= 11'h000;
                        div_out  <= ~div_out;
                    end else begin
                        slow_div <= slow_div + 11'h001;
                    end
                end
            end else if (div_in_rise && !dcfg.free_run) begin
                out_acc <= 26'h0000000;
                // Keep the toggle that falls on an input rise that restarts the accumulator
                if (out_acc + out_step >= half_target) begin
                    div_out <= ~div_out;
                end
            end else if (out_acc + out_step >= half_target) begin
                out_acc <= 26'h0000000;
                div_out <= ~div_out;
            end else begin
                out_acc <= out_acc + out_step;
            end
        end
    end

    // Register writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_ctrl <= {16'h0001, DIV_RST, 6'h00};
            dec_ctrl <= 32'h00000000;
            win_ul   <= 24'hFFFFFF;
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                REG_DIV_CTRL: begin
                    div_ctrl <= {reg_wdata[31:16],
                                 clamp_div(reg_wdata[15:6]),
                                 clamp_exp(reg_wdata[5:3]),
                                 1'b0, reg_wdata[1:0]};
                end
                REG_DEC_CTRL: dec_ctrl <= {1'b0, reg_wdata[30:0]};
                REG_WIN_UL:   win_ul   <= reg_wdata[23:0];
                default:      ;
            endcase
        end
    end

    // Register reads, data valid the cycle after the strobe
    assign stat = '{level_a: a_now, level_b: b_now, direction: dir_up,
                    in_window: in_win,
                    new_lines: line_trig | (cnt_edge & qualified)};
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (clk_en) begin
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                case (reg_addr)
                    REG_DIV_CTRL: reg_rdata <= div_ctrl;
                    REG_DEC_CTRL: reg_rdata <= dec_ctrl;
                    REG_WIN_UL:   reg_rdata <= {8'h00, win_ul};
                    REG_POS:      reg_rdata <= {8'h00, pos};
                    REG_STATUS:   reg_rdata <= {27'h0, stat};
                    default:      reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // elt_top

//--- design/elt_pkg.sv
// Constants, types and field layout for the encoder line trigger block
package elt_pkg;
    localparam int CLK_HZ        = 50000000;
    localparam int MIN_IN_HZ     = 1600;
    // Longest input period the loop tracks, in cycles (rounded down)
    localparam int SLOW_CYC      = CLK_HZ / MIN_IN_HZ;
    localparam int PER_W         = 16;
    localparam int POS_W         = 24;
    localparam int ADDR_W        = 4;
    // Register offsets
    localparam logic [3:0] REG_DIV_CTRL = 4'h0;
    localparam logic [3:0] REG_DEC_CTRL = 4'h4;
    localparam logic [3:0] REG_WIN_UL   = 4'h8;
    localparam logic [3:0] REG_POS      = 4'hC;
    localparam logic [3:0] REG_STATUS   = 4'h1;
    // Divider control layout
    localparam int F_EXP_LO  = 3;
    localparam int F_DIV_LO  = 6;
    localparam int F_STEP_LO = 16;
    localparam int F_FREE    = 0;
    localparam int F_STALL   = 1;
    localparam int F_FCLK    = 2;
    // Decoder control layout
    localparam int F_MULT    = 24;
    localparam int F_DIR_LO  = 25;
    localparam int F_WIN     = 27;
    localparam int F_SINGLE  = 28;
    localparam int F_STEP    = 30;
    localparam int F_RESET   = 31;
    localparam logic [2:0] EXP_MAX = 3'h6;
    localparam logic [9:0] DIV_MIN = 10'h001;
    localparam logic [9:0] DIV_RST = 10'h001;
    typedef enum logic [1:0] {
        ELT_DIR_BOTH = 2'b00,
        ELT_DIR_POS  = 2'b01,
        ELT_DIR_NEG  = 2'b10,
        ELT_DIR_RSVD = 2'b11
    } elt_dir_t;
    typedef struct packed {
        logic [2:0] exponent;
        logic [9:0] divisor;
        logic       free_run;
        logic       stall_hold;
    } elt_div_cfg_t;
    typedef struct packed {
        logic       level_a;
        logic       level_b;
        logic       direction;
        logic       in_window;
        logic       new_lines;
    } elt_status_t;
endpackage

//--- tb/elt_top_sva.sv
// Port checker for the encoder line trigger
module elt_top_sva
    import elt_pkg::*;
(
    // Clock and control
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        clk_en,
    // Pins and register port
    input wire logic        enc_a,
    input wire logic        enc_b,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Triggers
    input wire logic        line_trig,
    input wire logic        frame_trig,
    input wire logic        div_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_rd_idle: assert property (
        $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not idle");
    chk_line_pulse: assert property (
        line_trig |=> !line_trig) else $error("line pulse too long");
    chk_frame_pulse: assert property (
        frame_trig |=> !frame_trig) else $error("frame pulse too long");
    chk_line_cause: assert property (
        line_trig |-> {$past(enc_a, 3), $past(enc_b, 3)} !=
        {$past(enc_a, 5), $past(enc_b, 5)}) else $error("line without edge");
    chk_status_pins: assert property (
        reg_rd && reg_addr == REG_STATUS && enc_a == $past(enc_a, 5) &&
        enc_b == $past(enc_b, 5) |=> reg_rdata[31:3] ==
        {27'h0, $past(enc_a), $past(enc_b)}) else $error("bad pin status");
    chk_pos_width: assert property (
        reg_rd && reg_addr == REG_POS |=> reg_rdata[31:24] == 8'h00)
        else $error("position too wide");
    chk_unmapped_zero: assert property (
        reg_rd && !(reg_addr inside {4'h0, 4'h1, 4'h4, 4'h8, 4'hC})
        |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
    chk_div_fields: assert property (
        reg_rd && reg_addr == REG_DIV_CTRL |=> !reg_rdata[2] &&
        reg_rdata[5:3] <= 3'h6 && reg_rdata[15:6] != 10'h0)
        else $error("divider fields out of range");
    chk_reset_quiet: assert property (
        $fell(rst) |-> !line_trig && !frame_trig && !div_out &&
        reg_rdata == 32'h0) else $error("outputs active after reset");
endmodule // elt_top_sva

bind elt_top elt_top_sva elt_top_sva_i (.clk_sys(clk_sys), .rst(rst),
    .clk_en(clk_en), .enc_a(enc_a), .enc_b(enc_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .line_trig(line_trig),
    .frame_trig(frame_trig), .div_out(div_out));

//--- tb/elt_enc_model.sv
// Behavioural quadrature encoder driving the pins
module elt_enc_model (
    // Pacing clock
    input wire logic clk_sys,
    // Encoder pins
    output logic     enc_a,
    output logic     enc_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph = 2'h0;
    initial {enc_a, enc_b} = 2'b00;
    // Quarter steps, A leads when forward; gap 100 keeps 125 kHz
    task automatic step(input int n, input int gap);
        repeat (n < 0 ? -n : n) begin
            repeat (gap) @(posedge clk_sys);
            ph = (n < 0) ? ph - 2'h1 : ph + 2'h1;
            enc_a <= ph[1] ^ ph[0];
            enc_b <= ph[1];
        end
    endtask
endmodule // elt_enc_model

//--- tb/elt_top_tb.sv
// Self-checking bench for the encoder line trigger
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    miscompares++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module elt_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import elt_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst, clk_en, reg_wr, reg_rd, enc_a, enc_b;
    logic        line_trig, frame_trig, div_out;
    logic        div_q = 1'b0;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    int          miscompares, n_tests, n_lines, n_frames, n_div, l0, f0;
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        n_lines += (line_trig === 1'b1);
        n_frames += (frame_trig === 1'b1);
        n_div += (div_out === 1'b1 && div_q === 1'b0);
        div_q <= div_out;
    end
    elt_top elt_top_i (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
        .enc_a(enc_a), .enc_b(enc_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .line_trig(line_trig),
        .frame_trig(frame_trig), .div_out(div_out));
    elt_enc_model elt_enc_model_i (.clk_sys(clk_sys), .enc_a(enc_a),
        .enc_b(enc_b));
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys) reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] m, e,
                      input string nm);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys) reg_rd <= 1'b0;
        @(negedge clk_sys) `CHK(nm, e, reg_rdata & m)
        @(posedge clk_sys);
    endtask
    task automatic mvc(input int n, input int nl, input logic [23:0] p);
        l0 = n_lines;
        elt_enc_model_i.step(n, 100);
        repeat (8) @(posedge clk_sys);
        `CHK("lines", nl, n_lines - l0)
        rc(REG_POS, 32'hFFFFFF, {8'h0, p}, "pos");
    endtask
    function automatic logic [31:0] dc(logic r, s, sc, w,
                                       logic [1:0] dr, logic [23:0] ll);
        return {r, s, 1'b0, sc, w, dr, 1'b1, ll};
    endfunction
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #1600000;
        miscompares++;
        end_of_test;
    end
    initial begin
        {rst, clk_en, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        rst = 1'b1;
        clk_en = 1'b1;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rc(REG_DIV_CTRL, '1, 32'h0001_0040, "div");
        rc(REG_DEC_CTRL, '1, 32'h0, "dec");
        rc(REG_WIN_UL, '1, 32'h00FF_FFFF, "upper");
        rc(REG_POS, '1, 32'h0, "pos");
        wr(4'h2, '1);
        rc(4'h2, '1, 32'h0, "unmapped");
        clk_en <= 1'b0;
        wr(REG_WIN_UL, 32'h5);
        clk_en <= 1'b1;
        rc(REG_WIN_UL, '1, 32'h00FF_FFFF, "frozen");
        wr(REG_DIV_CTRL, 32'h0003_0038);
        rc(REG_DIV_CTRL, '1, 32'h0003_0070, "clamp");
        $display("access test done");
        mvc(4, 2, 24'h2);
        mvc(-4, 2, 24'h0);
        wr(REG_DEC_CTRL, dc(1, 0, 0, 0, 2'd0, 24'h0));
        mvc(1, 1, 24'h1);
        rc(REG_STATUS, 32'h1C, 32'h14, "fwd");
        mvc(-2, 2, 24'hFFFFFF);
        rc(REG_STATUS, 32'h1C, 32'h08, "rev");
        mvc(1, 1, 24'h0);
        $display("count test done");
        for (int i = 0; i < 4; i++) begin
            wr(REG_DEC_CTRL, dc(0, 0, 0, 0, i[1:0], 24'h0));
            mvc(4, i < 2 ? 4 : 0, 24'h4);
            mvc(-4, i % 2 == 0 ? 4 : 0, 24'h0);
        end
        $display("direction test done");
        wr(REG_WIN_UL, 32'h5);
        mvc(3, 0, 24'h3);
        wr(REG_DEC_CTRL, dc(1, 0, 0, 1, 2'd0, 24'h2));
        rc(REG_POS, '1, 32'h0, "clear");
        mvc(8, 4, 24'h8);
        wr(REG_DEC_CTRL, dc(0, 0, 0, 1, 2'd1, 24'h2));
        mvc(-5, 0, 24'h3);
        rc(REG_STATUS, 32'h2, 32'h2, "in window");
        mvc(-3, 0, 24'h0);
        $display("window test done");
        wr(REG_DEC_CTRL, dc(1, 0, 1, 0, 2'd0, 24'h0));
        mvc(4, 4, 24'h4);
        mvc(-2, 0, 24'h2);
        mvc(2, 0, 24'h4);
        mvc(2, 2, 24'h6);
        wr(REG_DEC_CTRL, dc(1, 0, 1, 0, 2'd2, 24'h0));
        mvc(-2, 2, 24'hFFFFFE);
        mvc(1, 0, 24'hFFFFFF);
        mvc(-2, 1, 24'hFFFFFD);
        $display("single capture test done");
        wr(REG_DEC_CTRL, dc(1, 1, 0, 0, 2'd0, 24'h0));
        f0 = n_frames;
        mvc(9, 9, 24'h9);
        `CHK("frames", 3, n_frames - f0)
        wr(REG_DIV_CTRL, 32'h0002_0040);
        wr(REG_DEC_CTRL, dc(1, 1, 1, 1, 2'd1, 24'h2));
        f0 = n_frames;
        mvc(6, 4, 24'h6);
        mvc(-3, 0, 24'h3);
        mvc(3, 0, 24'h6);
        `CHK("frames", 2, n_frames - f0)
        $display("step test done");
        wr(REG_DIV_CTRL, 32'h0001_0052);
        elt_enc_model_i.step(16, 100);
        f0 = n_div;
        elt_enc_model_i.step(16, 100);
        `CHK("div rate", 1'b1, (n_div - f0) inside {[14:18]})
        repeat (32000) @(posedge clk_sys);
        f0 = n_div;
        repeat (2000) @(posedge clk_sys);
        `CHK("stall", 0, n_div - f0)
        $display("divider test done");
        end_of_test;
    end
endmodule // elt_top_tb
